// File: core/ecs_nvm_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ecs_nvm_ctrl #(
    parameter int PROG_CYCLES = ecs_pkg::PROG_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire ecs_pkg::ecs_acc_s         acc,
    output logic [7:0]                     rd_data,
    output logic                           rd_valid,
    input  wire logic [ecs_pkg::PAGE_W-1:0] sram_page_select,
    input  wire logic                      aon_clk_active,
    input  wire ecs_pkg::ecs_rsp_s         rsp,
    output ecs_pkg::ecs_req_s              req
);
    import ecs_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    ecs_state_e        state_q, state_d;
    logic [1:0]        aon_sync_q;
    logic              load_pend_q, copy_pend_q, unlock_q, acrc_q, crc_err_q;
    logic [7:0]        cnt_q, lcrc_q, rd_data_q;
    logic              rd_valid_q;
    logic [31:0]       tmr_q;
    ecs_req_s          req_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire        aon_ok     = aon_sync_q[1];
    wire        wr_ctl     = acc.wr && (acc.addr == ADDR_CTL);
    wire        wr_unlk    = acc.wr && (acc.addr == ADDR_UNLK);
    wire        is_idle    = (state_q == ST_IDLE);
    wire        is_load    = (state_q == ST_LOAD);
    wire        is_prog    = (state_q == ST_PROG);
    wire        prog_go    = wr_ctl && acc.wdata[BIT_PROG] && unlock_q && is_idle;
    wire        tmr_end    = is_prog && (tmr_q == 32'(PROG_CYCLES - 1));
    wire        start_load = is_idle && load_pend_q && aon_ok && !prog_go;
    wire        start_copy = is_idle && copy_pend_q && !load_pend_q && !prog_go;
    wire [7:0]  cnt_inc    = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 8'h01;
    wire [7:0]  ctl_rd     = {1'b0, copy_pend_q, crc_err_q, acrc_q, load_pend_q,
                              is_prog, 2'b00};
    wire [7:0]  rd_mux     = (acc.addr == ADDR_CNT)  ? cnt_q  :
                             (acc.addr == ADDR_CTL)  ? ctl_rd :
                             (acc.addr == ADDR_LCRC) ? lcrc_q : 8'h00;

    assign rd_data  = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign req      = req_q;

    // ----------------------------------------
    // Always-on clock status synchroniser
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aon_sync_q <= 2'b00;
        end else begin
            aon_sync_q <= {aon_sync_q[0], aon_clk_active};
        end
    end

    // ----------------------------------------
    // Operation sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (prog_go) begin
                    state_d = ST_PROG;
                end else if (start_load) begin
                    state_d = ST_LOAD;
                end else if (start_copy) begin
                    state_d = ST_COPY;
                end
            end
            ST_LOAD: begin
                if (rsp.load_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_COPY: begin
                if (rsp.copy_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_PROG: begin
                if (tmr_end) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Program cycle timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr_q <= 32'h0;
        end else begin
            tmr_q <= is_prog ? tmr_q + 32'h1 : 32'h0;
        end
    end

    // ----------------------------------------
    // Request flags; set beats clear
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_pend_q <= 1'b1;
            copy_pend_q <= 1'b0;
        end else begin
            if (wr_ctl && acc.wdata[BIT_LOAD] && !is_prog) begin
                load_pend_q <= 1'b1;
            end else if (is_load && rsp.load_done) begin
                load_pend_q <= 1'b0;
            end
            if (wr_ctl && acc.wdata[BIT_COPY] && !is_prog) begin
                copy_pend_q <= 1'b1;
            end else if (state_q == ST_COPY && rsp.copy_done) begin
                copy_pend_q <= 1'b0;
            end
        end
    end

    // Unlock arming: the key write arms it, any other access disarms it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unlock_q <= 1'b0;
        end else if (acc.wr || acc.rd) begin
            unlock_q <= wr_unlk && (acc.wdata == UNLK_CODE);
        end
    end

    // Auto CRC enable, software owned
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acrc_q <= RST_ACRC;
        end else if (wr_ctl) begin
            acrc_q <= acc.wdata[BIT_ACRC];
        end
    end

    // ----------------------------------------
    // Count, live CRC and CRC error
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q     <= RST_CNT;
            lcrc_q    <= RST_LCRC;
            crc_err_q <= 1'b0;
        end else if (is_load && rsp.load_done) begin
            cnt_q     <= rsp.count;
            lcrc_q    <= rsp.crc;
            crc_err_q <= rsp.crc_err;
        end else if (tmr_end) begin
            cnt_q     <= cnt_inc;
        end
    end

    // ----------------------------------------
    // Memory request pulses, plus auto CRC, page and count levels
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_q <= '0;
        end else begin
            req_q.load     <= start_load;
            req_q.copy     <= start_copy;
            req_q.prog     <= prog_go;
            req_q.auto_crc <= acrc_q;
            req_q.page     <= sram_page_select;
            req_q.count    <= tmr_end ? cnt_inc : cnt_q;
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= acc.rd && !is_load;
            rd_data_q  <= (acc.rd && !is_load) ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_busy_hold;
        @(posedge clk) disable iff (rst)
        $rose(is_prog) |-> is_prog[*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

    property p_sat;
        @(posedge clk) disable iff (rst)
        (tmr_end && cnt_q == CNT_MAX) |=> (cnt_q == CNT_MAX);
    endproperty
    a_sat: assert property (p_sat) else $error("count passed saturation");

    property p_inc;
        @(posedge clk) disable iff (rst)
        (tmr_end && cnt_q != CNT_MAX) |=> (cnt_q == $past(cnt_q) + 8'h01);
    endproperty
    a_inc: assert property (p_inc) else $error("count not incremented");

    property p_locked;
        @(posedge clk) disable iff (rst)
        (is_idle && wr_ctl && acc.wdata[BIT_PROG] && !unlock_q) |=> !is_prog;
    endproperty
    a_locked: assert property (p_locked) else $error("program without unlock");

    property p_go;
        @(posedge clk) disable iff (rst)
        prog_go |=> is_prog && req_q.prog ##1 !req_q.prog;
    endproperty
    a_go: assert property (p_go) else $error("program did not start");

    property p_load_clr;
        @(posedge clk) disable iff (rst)
        (is_load && rsp.load_done && !(wr_ctl && acc.wdata[BIT_LOAD])) |=> !load_pend_q && (lcrc_q == $past(rsp.crc));
    endproperty
    a_load_clr: assert property (p_load_clr) else $error("load result wrong");

    property p_crc_err;
        @(posedge clk) disable iff (rst)
        (is_load && rsp.load_done) |=> (crc_err_q == $past(rsp.crc_err));
    endproperty
    a_crc_err: assert property (p_crc_err) else $error("crc flag wrong");

    property p_rd_block;
        @(posedge clk) disable iff (rst)
        (is_load && acc.rd) |=> !rd_valid;
    endproperty
    a_rd_block: assert property (p_rd_block) else $error("read during load");

    property p_aon;
        @(posedge clk) disable iff (rst)
        (is_idle && !aon_ok) |=> !is_load;
    endproperty
    a_aon: assert property (p_aon) else $error("load without clock");

    property p_copy_page;
        @(posedge clk) disable iff (rst)
        start_copy |=> req_q.copy && (req_q.page == $past(sram_page_select));
    endproperty
    a_copy_page: assert property (p_copy_page) else $error("copy page wrong");

    property p_cnt_load;
        @(posedge clk) disable iff (rst)
        (is_load && rsp.load_done) |=> (cnt_q == $past(rsp.count));
    endproperty
    a_cnt_load: assert property (p_cnt_load) else $error("count not reloaded");

    property p_rd_lcrc;
        @(posedge clk) disable iff (rst)
        (acc.rd && !is_load && acc.addr == ADDR_LCRC) |=> (rd_data == $past(lcrc_q));
    endproperty
    a_rd_lcrc: assert property (p_rd_lcrc) else $error("live crc read wrong");

    property p_busy_ignore;
        @(posedge clk) disable iff (rst)
        (is_prog && wr_ctl && !load_pend_q && !copy_pend_q) |=> (!load_pend_q && !copy_pend_q);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("request taken while busy");

    property p_unlk_cancel;
        @(posedge clk) disable iff (rst)
        ((acc.wr || acc.rd) && !wr_unlk) |=> !unlock_q;
    endproperty
    a_unlk_cancel: assert property (p_unlk_cancel) else $error("unlock kept after other access");

    c_prog:  cover property (@(posedge clk) disable iff (rst) tmr_end);
    c_load:  cover property (@(posedge clk) disable iff (rst) is_load && rsp.load_done);
    c_copy:  cover property (@(posedge clk) disable iff (rst) start_copy);
    c_crce:  cover property (@(posedge clk) disable iff (rst) is_load && rsp.load_done && rsp.crc_err);
    c_sat:   cover property (@(posedge clk) disable iff (rst) tmr_end && cnt_q == CNT_MAX);
endmodule
`default_nettype wire

// File: core/ecs_pkg.sv
package ecs_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CNT  = 8'h88;
    localparam logic [7:0] ADDR_CTL  = 8'h89;
    localparam logic [7:0] ADDR_LCRC = 8'h8a;
    localparam logic [7:0] ADDR_UNLK = 8'hea;  // Unlock key register offset
    localparam logic [7:0] UNLK_CODE = 8'h5a;  // Unlock key value

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int BIT_COPY  = 6;
    localparam int BIT_CRCE  = 5;
    localparam int BIT_ACRC  = 4;
    localparam int BIT_LOAD  = 3;
    localparam int BIT_BUSY  = 2;
    localparam int BIT_PROG  = 0;
    localparam logic RST_ACRC = 1'b1;
    localparam logic [7:0] RST_CNT  = 8'h00;
    localparam logic [7:0] RST_LCRC = 8'h00;
    localparam logic [7:0] CNT_MAX  = 8'hff;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ      = 200;
    localparam int PROG_TIME_MS = 230;
    localparam int PROG_CYC     = PROG_TIME_MS * 1000 * CLK_MHZ;
    localparam int PAGE_W       = 2;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ecs_acc_s;

    typedef struct packed {
        logic              load;
        logic              copy;
        logic              prog;
        logic              auto_crc;
        logic [PAGE_W-1:0] page;
        logic [7:0]        count;
    } ecs_req_s;

    typedef struct packed {
        logic       load_done;
        logic       copy_done;
        logic       crc_err;
        logic [7:0] crc;
        logic [7:0] count;
    } ecs_rsp_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_COPY = 4'b0100,
        ST_PROG = 4'b1000
    } ecs_state_e;
endpackage

// File: sim/ecs_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Memory side: answers loads and copies, keeps the program count
// ----------------------------------------
module ecs_mem_model #(
    parameter logic [7:0] CNT_INIT = 8'hfe,
    parameter logic [3:0] LAT      = 4'h6
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire ecs_pkg::ecs_req_s req,
    output ecs_pkg::ecs_rsp_s      rsp
);
    import ecs_pkg::*;
    logic [7:0] cnt_q;
    logic [7:0] crc_q;
    logic       err_q;
    logic [1:0] seen_q;
    logic [3:0] wl_q;
    logic [3:0] wc_q;
    // Done pulses; results shown only with load_done, scrambled otherwise
    assign rsp.load_done = (wl_q == 4'h1);
    assign rsp.copy_done = (wc_q == 4'h1);
    assign rsp.crc       = rsp.load_done ? crc_q : ~crc_q;
    assign rsp.count     = rsp.load_done ? cnt_q : ~cnt_q;
    assign rsp.crc_err   = rsp.load_done ? err_q : ~err_q;
    // Timers, CRC pattern and stored count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q  <= CNT_INIT;
            crc_q  <= 8'h11;
            err_q  <= 1'b0;
            seen_q <= 2'h0;
            wl_q   <= 4'h0;
            wc_q   <= 4'h0;
        end else begin
            wl_q <= req.load ? LAT : (wl_q != 4'h0) ? wl_q - 4'h1 : wl_q;
            wc_q <= req.copy ? LAT : (wc_q != 4'h0) ? wc_q - 4'h1 : wc_q;
            seen_q <= {seen_q[0], seen_q[0] | rsp.load_done};
            if (rsp.load_done) begin
                crc_q <= crc_q + 8'h11;
                err_q <= ~err_q;
            end
            if (seen_q[1] && req.count != cnt_q) begin
                cnt_q <= req.count;  // Stored count kept in memory
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_ecs_nvm_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ecs_nvm_ctrl;
    import ecs_pkg::*;
    localparam int PC = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic aon = 1'b0;
    logic [1:0] page = 2'h0;
    ecs_acc_s acc = '0;
    ecs_req_s req;
    ecs_rsp_s rsp;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [1:0] page_seen = 2'h0;
    int n_errors = 0;
    int comparisons = 0;
    int n_load = 0;
    int n_copy = 0;
    int n_prog = 0;
    int cyc = 0;
    logic [7:0] d;
    logic v;
    // ----------------------------------------
    // Design and memory model
    // ----------------------------------------
    ecs_nvm_ctrl #(.PROG_CYCLES(PC)) u_ecs_nvm_ctrl (.clk(clk), .rst(rst), .acc(acc), .rd_data(rd_data),
        .rd_valid(rd_valid), .sram_page_select(page), .aon_clk_active(aon), .rsp(rsp), .req(req));
    ecs_mem_model u_ecs_mem_model (.clk(clk), .rst(rst), .req(req), .rsp(rsp));
    // Clock, request monitor and hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (req.load === 1'b1) n_load++;
        if (req.prog === 1'b1) n_prog++;
        if (req.copy === 1'b1) begin
            n_copy++;
            page_seen <= req.page;
        end
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge clk) acc = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(negedge clk) acc = '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk) acc = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk) begin
            v = rd_valid;
            d = rd_data;
            acc = '0;
        end
    endtask
    task automatic wait_load();
        for (int i = 0; i < 200 && rsp.load_done !== 1'b1; i++) @(posedge clk);
        repeat (3) @(negedge clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_boot();
        repeat (30) @(negedge clk);
        chk("load without aon", 8'(n_load), 8'h00);
        aon = 1'b1;
        wait_load();
        chk("boot load", 8'(n_load), 8'h01);
        rd(ADDR_CNT);
        chk("count", d, 8'hfe);
        rd(ADDR_LCRC);
        chk("live crc", d, 8'h11);
        rd(ADDR_CTL);
        chk("ctl", d, 8'h10);
        chk("auto crc", req.auto_crc, 1'b1);
        rd(8'h00);
        chk("unmapped", {v, d[6:0]}, 8'h80);
        $display("done boot");
    endtask
    task automatic t_reload();
        wr(ADDR_CTL, 8'h18);
        rd(ADDR_CNT);
        chk("read in load", v, 1'b0);
        wait_load();
        chk("reload", 8'(n_load), 8'h02);
        rd(ADDR_CTL);
        chk("ctl after load", d, 8'h30);
        rd(ADDR_LCRC);
        chk("live crc 2", d, 8'h22);
        $display("done reload");
    endtask
    task automatic t_prog(input logic [7:0] exp_cnt, input int np);
        wr(ADDR_UNLK, UNLK_CODE);
        wr(ADDR_CTL, 8'h11);
        @(negedge clk);
        chk("prog start", 8'(n_prog), 8'(np));
        rd(ADDR_CTL);
        chk("busy", d, 8'h34);
        wr(ADDR_CTL, 8'h18);
        wr(ADDR_UNLK, UNLK_CODE);
        wr(ADDR_CTL, 8'h11);
        @(negedge clk);
        chk("busy ignores", 8'(n_load * 16 + n_prog), 8'(32 + np));
        repeat (PC + 5) @(negedge clk);
        rd(ADDR_CTL);
        chk("prog end", d, 8'h30);
        rd(ADDR_CNT);
        chk("count after prog", d, exp_cnt);
        $display("done prog");
    endtask
    task automatic t_refuse();
        wr(ADDR_UNLK, UNLK_CODE);
        rd(ADDR_CNT);
        wr(ADDR_CTL, 8'h11);
        @(negedge clk);
        chk("cancelled unlock", 8'(n_prog), 8'h02);
        wr(ADDR_UNLK, 8'h5b);
        wr(ADDR_CTL, 8'h11);
        @(negedge clk);
        chk("wrong key", 8'(n_prog), 8'h02);
        $display("done refuse");
    endtask
    task automatic t_copy();
        page = 2'h2;
        wr(ADDR_CTL, 8'h50);
        rd(ADDR_CTL);
        chk("copy pending", d, 8'h70);
        repeat (10) @(negedge clk);
        chk("copy page", page_seen, 2'h2);
        chk("copy count", 8'(n_copy), 8'h01);
        rd(ADDR_CTL);
        chk("copy cleared", d, 8'h30);
        $display("done copy");
    endtask
    task automatic t_store();
        wr(ADDR_CTL, 8'h08);
        wait_load();
        chk("store load", 8'(n_load), 8'h03);
        rd(ADDR_CNT);
        chk("stored count", d, 8'hff);
        rd(ADDR_LCRC);
        chk("live crc 3", d, 8'h33);
        rd(ADDR_CTL);
        chk("ctl crc clear", d, 8'h00);
        chk("auto crc off", req.auto_crc, 1'b0);
        $display("done store");
    endtask
    task automatic stop_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_boot();
        t_reload();
        t_prog(8'hff, 1);
        t_prog(8'hff, 2);
        t_refuse();
        t_copy();
        t_store();
        stop_test();
    end
endmodule
`default_nettype wire
